// ==== hw/sgsfs_pkg.sv ====
// Constants and carrier types for the gain set and speed feedback selector.
// Assumes a single 200 MHz system clock and a fixed control period.
package sgsfs_pkg;
   // Clock and control period
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int CTRL_PERIOD_NS   = 100000;
   localparam int CTRL_TICK_CYCLES = CTRL_PERIOD_NS * 1000 / CLK_PERIOD_PS;
   // Filter time counts in 0.01 ms, so ten units per control period
   localparam logic [15:0] FILT_UNITS_PER_TICK = 16'h000A;
   localparam int          FILT_SHIFT_MAX      = 15;
   localparam int          OBS_SHIFT           = 10;
   // Widths
   localparam int SPD_W  = 32;
   localparam int PAR_W  = 16;
   localparam int MODE_W = 4;
   // Gain switch modes
   localparam logic [3:0] MODE_FIXED_FIRST  = 4'h0;
   localparam logic [3:0] MODE_EXT_SELECT   = 4'h1;
   localparam logic [3:0] MODE_TORQUE_REF   = 4'h2;
   localparam logic [3:0] MODE_DEVIATION    = 4'h3;
   localparam logic [3:0] MODE_ACCEL        = 4'h4;
   localparam logic [3:0] MODE_SPEED_REF    = 4'h5;
   localparam logic [3:0] MODE_POS_REF      = 4'h6;
   localparam logic [3:0] MODE_ACT_SPEED    = 4'h7;
   localparam logic [3:0] MODE_POS_AND_SPD  = 4'h8;
   localparam logic [3:0] MODE_FIXED_SECOND = 4'h9;
   localparam logic [3:0] MODE_POS_DONE     = 4'hA;
   // Feedback source codes and reset values
   localparam logic       FB_ENCODER  = 1'b0;
   localparam logic       FB_OBSERVER = 1'b1;
   localparam logic [3:0] MODE_RST    = 4'h0;
   localparam logic       FB_RST      = 1'b0;

   typedef enum logic [0:0] {
      SGSFS_SET_FIRST  = 1'b0,
      SGSFS_SET_SECOND = 1'b1
   } sgsfs_set_t;

   typedef struct packed {
      logic [15:0] speed_gain;
      logic [15:0] speed_int_time;
      logic [15:0] pos_gain;
      logic [15:0] torque_filt_time;
   } sgsfs_gain_set_t;

   typedef struct packed {
      logic signed [31:0] torque_ref;
      logic signed [31:0] deviation;
      logic signed [31:0] accel;
      logic signed [31:0] speed_ref;
      logic signed [31:0] pos_ref;
   } sgsfs_monitor_t;

   typedef struct packed {
      logic [15:0] torque_ref_thr;
      logic [15:0] deviation_thr;
      logic [15:0] accel_thr;
      logic [15:0] speed_ref_thr;
      logic [15:0] pos_ref_thr;
      logic [15:0] act_speed_thr;
      logic [15:0] hysteresis;
      logic [15:0] delay_time;
      logic [15:0] ramp_time;
   } sgsfs_switch_cfg_t;
endpackage

// ==== hw/sgsfs_top.sv ====
// Gain set selection and speed feedback source selection for the servo loop.
// Assumes monitored quantities and encoder position come from logic on the same
// clock; only the external gain select input is asynchronous.
//
// Summary of operation
// - Feedback is encoder speed at 0, observer speed at 1; latched after restart.
// - Encoder speed is the position difference between successive control samples.
// - An observer estimates motor speed; it is output and selectable as feedback.
// - Observer gain acts at once; larger gain tracks actual speed more closely.
// - Encoder speed passes a low-pass filter set by the live filter time.
// - Two gain sets of four values; one drives the loops, except that a nonzero ramp time blends position gain between sets.
// - First set by default and always in mode 0.
// - Mode 1 selects second set while the external select input is active.
// - Mode 10 selects second set while positioning completed is set.
// - Modes 2 to 7 select second set while the quantity exceeds its threshold.
// - Threshold modes use hysteresis around the threshold against chatter.
// - Mode 8 position condition needs position reference above threshold plus hysteresis.
// - Mode 8 needs position condition and actual speed above speed threshold.
// - Mode 9 always selects the second set.
// - Mode latched at restart; thresholds, delay, ramp and hysteresis act at once.
`timescale 1ns/1ps
module sgsfs_top #(
   parameter int TICK_CYCLES = sgsfs_pkg::CTRL_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                                i_sys_clk,
   input  wire logic                                i_rst_b,
   // Configuration
   input  wire logic [3:0]                          i_gain_switch_mode,
   input  wire logic                                i_feedback_speed_source_select,
   input  wire logic [15:0]                         i_observer_gain,
   input  wire logic [15:0]                         i_encoder_speed_filter_time,
   input  wire sgsfs_pkg::sgsfs_switch_cfg_t        i_switch_cfg,
   input  wire sgsfs_pkg::sgsfs_gain_set_t          i_gain_first,
   input  wire sgsfs_pkg::sgsfs_gain_set_t          i_gain_second,
   // Loop signals
   input  wire logic signed [31:0]                  i_encoder_position,
   input  wire sgsfs_pkg::sgsfs_monitor_t           i_monitor,
   input  wire logic                                i_positioning_completed,
   input  wire logic                                i_gain_select_input,
   // Results
   output logic signed [31:0]                       o_encoder_speed,
   output logic signed [31:0]                       o_observer_speed,
   output logic signed [31:0]                       o_feedback_speed,
   output logic                                     o_second_set_active,
   output sgsfs_pkg::sgsfs_gain_set_t               o_active_gains
);

   localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   function automatic logic [31:0] mag(input logic signed [31:0] v);
      mag = v[31] ? 32'(-v) : 32'(v);
   endfunction

   // Filter shift grows with the time constant in control periods
   function automatic logic [3:0] filt_shift(input logic [15:0] t);
      logic [15:0] ratio;
      logic [3:0]  s;
      ratio = t / sgsfs_pkg::FILT_UNITS_PER_TICK;
      s = 4'h0;
      for (int i = 0; i < sgsfs_pkg::FILT_SHIFT_MAX; i++) begin
         if ((ratio >> i) != 16'h0000) begin
            s = 4'(i + 1);
         end
      end
      filt_shift = s;
   endfunction

   // Registers
   logic [TW-1:0]          tick_cnt_reg, tick_cnt_next;
   logic                   loaded_reg, loaded_next;
   logic [3:0]             mode_reg, mode_next;
   logic                   fb_sel_reg, fb_sel_next;
   logic [1:0]             gsel_sync_reg;
   logic signed [31:0]     pos_prev_reg, pos_prev_next;
   logic signed [31:0]     enc_raw_reg, enc_raw_next;
   logic signed [31:0]     enc_filt_reg, enc_filt_next;
   logic signed [31:0]     obs_reg, obs_next;
   logic                   hys_reg, hys_next;
   sgsfs_pkg::sgsfs_set_t  set_reg, set_next;
   logic [15:0]            dly_cnt_reg, dly_cnt_next;
   logic                   ramp_reg, ramp_next;
   logic [15:0]            ramp_cnt_reg, ramp_cnt_next;
   logic [15:0]            ramp_from_reg, ramp_from_next;
   sgsfs_pkg::sgsfs_gain_set_t gains_reg, gains_next;

   // Combinational terms
   logic                   tick;
   logic signed [31:0]     fb_speed;
   logic [31:0]            watched;
   logic [15:0]            thr;
   logic [31:0]            thr_up;
   logic [31:0]            thr_dn;
   logic                   want_second;
   sgsfs_pkg::sgsfs_gain_set_t target;
   logic signed [47:0]     obs_corr;
   logic signed [32:0]     ramp_span;
   logic signed [49:0]     ramp_step;

   always_comb begin
      tick        = (tick_cnt_reg == TICK_LAST);
      fb_speed    = (fb_sel_reg == sgsfs_pkg::FB_OBSERVER) ? obs_reg : enc_filt_reg;
      target      = (set_reg == sgsfs_pkg::SGSFS_SET_SECOND) ? i_gain_second
                                                               : i_gain_first;
      watched     = 32'h0000_0000;
      thr         = 16'h0000;
      unique case (mode_reg)
         sgsfs_pkg::MODE_TORQUE_REF: begin
            watched = mag(i_monitor.torque_ref);
            thr     = i_switch_cfg.torque_ref_thr;
         end
         sgsfs_pkg::MODE_DEVIATION: begin
            watched = mag(i_monitor.deviation);
            thr     = i_switch_cfg.deviation_thr;
         end
         sgsfs_pkg::MODE_ACCEL: begin
            watched = mag(i_monitor.accel);
            thr     = i_switch_cfg.accel_thr;
         end
         sgsfs_pkg::MODE_SPEED_REF: begin
            watched = mag(i_monitor.speed_ref);
            thr     = i_switch_cfg.speed_ref_thr;
         end
         sgsfs_pkg::MODE_ACT_SPEED: begin
            watched = mag(fb_speed);
            thr     = i_switch_cfg.act_speed_thr;
         end
         sgsfs_pkg::MODE_POS_REF, sgsfs_pkg::MODE_POS_AND_SPD: begin
            watched = mag(i_monitor.pos_ref);
            thr     = i_switch_cfg.pos_ref_thr;
         end
         default: begin
            watched = 32'h0000_0000;
            thr     = 16'h0000;
         end
      endcase
      // Set above threshold plus band, release at threshold minus band
      thr_up = 32'(thr) + 32'(i_switch_cfg.hysteresis);
      thr_dn = (thr > i_switch_cfg.hysteresis) ? 32'(thr - i_switch_cfg.hysteresis) : 32'h0;
      hys_next = hys_reg;
      if (tick) begin
         hys_next = hys_reg ? (watched > thr_dn) : (watched > thr_up);
      end
      unique case (mode_reg)
         sgsfs_pkg::MODE_FIXED_FIRST:  want_second = 1'b0;
         sgsfs_pkg::MODE_EXT_SELECT:   want_second = gsel_sync_reg[1];
         sgsfs_pkg::MODE_POS_DONE:     want_second = i_positioning_completed;
         sgsfs_pkg::MODE_FIXED_SECOND: want_second = 1'b1;
         sgsfs_pkg::MODE_POS_AND_SPD:  want_second = hys_reg &&
            (mag(fb_speed) > 32'(i_switch_cfg.act_speed_thr));
         sgsfs_pkg::MODE_TORQUE_REF, sgsfs_pkg::MODE_DEVIATION, sgsfs_pkg::MODE_ACCEL,
         sgsfs_pkg::MODE_SPEED_REF, sgsfs_pkg::MODE_POS_REF,
         sgsfs_pkg::MODE_ACT_SPEED:    want_second = hys_reg;
         default:                      want_second = 1'b0;
      endcase
   end

   // Control tick, restart latch and speed path
   always_comb begin
      tick_cnt_next  = tick ? '0 : TW'(tick_cnt_reg + 1'b1);
      // Mode and source are taken once, the cycle after restart ends
      loaded_next    = 1'b1;
      mode_next      = loaded_reg ? mode_reg : i_gain_switch_mode;
      fb_sel_next    = loaded_reg ? fb_sel_reg : i_feedback_speed_source_select;
      pos_prev_next  = pos_prev_reg;
      enc_raw_next   = enc_raw_reg;
      enc_filt_next  = enc_filt_reg;
      obs_next       = obs_reg;
      obs_corr       = 48'(enc_raw_reg - obs_reg) * $signed({1'b0, i_observer_gain});
      if (tick) begin
         pos_prev_next = i_encoder_position;
         enc_raw_next  = i_encoder_position - pos_prev_reg;
         enc_filt_next = enc_filt_reg +
            ((enc_raw_reg - enc_filt_reg) >>> filt_shift(i_encoder_speed_filter_time));
         // Correction scales with the live gain, so a larger gain tracks tighter
         obs_next = obs_reg + 32'(obs_corr >>> sgsfs_pkg::OBS_SHIFT);
      end
   end

   // Gain set selection, delay and position gain ramp
   always_comb begin
      set_next       = set_reg;
      dly_cnt_next   = dly_cnt_reg;
      ramp_next      = ramp_reg;
      ramp_cnt_next  = ramp_cnt_reg;
      ramp_from_next = ramp_from_reg;
      if (tick) begin
         if (want_second != (set_reg == sgsfs_pkg::SGSFS_SET_SECOND)) begin
            if (dly_cnt_reg >= i_switch_cfg.delay_time) begin
               set_next       = want_second ? sgsfs_pkg::SGSFS_SET_SECOND
                                            : sgsfs_pkg::SGSFS_SET_FIRST;
               dly_cnt_next   = 16'h0000;
               ramp_next      = (i_switch_cfg.ramp_time != 16'h0000);
               ramp_cnt_next  = 16'h0000;
               ramp_from_next = gains_reg.pos_gain;
            end else begin
               dly_cnt_next = dly_cnt_reg + 16'h0001;
            end
         end else begin
            dly_cnt_next = 16'h0000;
         end
         if (ramp_reg) begin
            ramp_cnt_next = ramp_cnt_reg + 16'h0001;
            if (ramp_cnt_next >= i_switch_cfg.ramp_time) begin
               ramp_next = 1'b0;
            end
         end
      end
      // Ramp output is recomputed every cycle so a shortened ramp time acts at once
      ramp_span  = $signed({1'b0, target.pos_gain}) - $signed({1'b0, ramp_from_reg});
      ramp_step  = 50'(ramp_span * $signed({1'b0, ramp_cnt_reg})) /
                   $signed({34'h0, (i_switch_cfg.ramp_time == 16'h0000) ? 16'h0001
                                                                       : i_switch_cfg.ramp_time});
      gains_next = target;
      if (ramp_reg) begin
         gains_next.pos_gain = 16'($signed({1'b0, ramp_from_reg}) + ramp_step);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      gsel_sync_reg <= {gsel_sync_reg[0], i_gain_select_input};
      if (!i_rst_b) begin
         tick_cnt_reg  <= '0;
         loaded_reg    <= 1'b0;
         mode_reg      <= sgsfs_pkg::MODE_RST;
         fb_sel_reg    <= sgsfs_pkg::FB_RST;
         pos_prev_reg  <= 32'sh0000_0000;
         enc_raw_reg   <= 32'sh0000_0000;
         enc_filt_reg  <= 32'sh0000_0000;
         obs_reg       <= 32'sh0000_0000;
         hys_reg       <= 1'b0;
         set_reg       <= sgsfs_pkg::SGSFS_SET_FIRST;
         dly_cnt_reg   <= 16'h0000;
         ramp_reg      <= 1'b0;
         ramp_cnt_reg  <= 16'h0000;
         ramp_from_reg <= 16'h0000;
         gains_reg     <= '0;
      end else begin
         tick_cnt_reg  <= tick_cnt_next;
         loaded_reg    <= loaded_next;
         mode_reg      <= mode_next;
         fb_sel_reg    <= fb_sel_next;
         pos_prev_reg  <= pos_prev_next;
         enc_raw_reg   <= enc_raw_next;
         enc_filt_reg  <= enc_filt_next;
         obs_reg       <= obs_next;
         hys_reg       <= hys_next;
         set_reg       <= set_next;
         dly_cnt_reg   <= dly_cnt_next;
         ramp_reg      <= ramp_next;
         ramp_cnt_reg  <= ramp_cnt_next;
         ramp_from_reg <= ramp_from_next;
         gains_reg     <= gains_next;
      end
   end

   assign o_encoder_speed     = enc_filt_reg;
   assign o_observer_speed    = obs_reg;
   assign o_feedback_speed    = fb_speed;
   assign o_second_set_active = (set_reg == sgsfs_pkg::SGSFS_SET_SECOND);
   assign o_active_gains      = gains_reg;

endmodule

// ==== verif/sgsfs_asserts.sv ====
// Checker for the gain set and feedback selector, bound to sgsfs_top.
// Assumes the sgsfs_pkg types and a control tick of 8 to 10 clocks.
`timescale 1ns/1ps
module sgsfs_asserts #(
   parameter int TICK_CYCLES = 8
) (
   // Clock and reset
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_rst_b,
   // Watched inputs
   input  wire logic [3:0]                    i_gain_switch_mode,
   input  wire logic                          i_feedback_speed_source_select,
   input  wire sgsfs_pkg::sgsfs_switch_cfg_t  i_switch_cfg,
   input  wire sgsfs_pkg::sgsfs_gain_set_t    i_gain_first,
   input  wire sgsfs_pkg::sgsfs_gain_set_t    i_gain_second,
   input  wire logic                          i_gain_select_input,
   // Watched outputs
   input  wire logic signed [31:0]            o_encoder_speed,
   input  wire logic signed [31:0]            o_observer_speed,
   input  wire logic signed [31:0]            o_feedback_speed,
   input  wire logic                          o_second_set_active,
   input  wire sgsfs_pkg::sgsfs_gain_set_t    o_active_gains
);
   logic       rst_d_reg;
   logic       src_reg;
   logic [3:0] mode_reg;
   logic [7:0] age_reg;
   // Copies of the restart latch, so later writes to the inputs cannot fool us
   always_ff @(posedge i_sys_clk) begin
      rst_d_reg <= i_rst_b;
      age_reg <= !i_rst_b ? 8'h00 : (age_reg == 8'hFF ? age_reg : age_reg + 8'h01);
      if (i_rst_b && !rst_d_reg) begin
         mode_reg <= i_gain_switch_mode;
         src_reg <= i_feedback_speed_source_select;
      end
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   chk_reset_first_set: assert property (disable iff (1'b0) !i_rst_b |=>
      !o_second_set_active && o_active_gains == '0) else $error("set not cleared by reset");
   chk_first_gains_follow: assert property (age_reg >= 8'h03 && !o_second_set_active |=>
      o_active_gains.speed_gain == $past(i_gain_first.speed_gain)
      && o_active_gains.torque_filt_time == $past(i_gain_first.torque_filt_time))
      else $error("first set gains not driven");
   chk_second_gains_follow: assert property (age_reg >= 8'h03 && o_second_set_active |=>
      o_active_gains.speed_int_time == $past(i_gain_second.speed_int_time))
      else $error("second set gains not driven");
   chk_feedback_source_mux: assert property (rst_d_reg |->
      o_feedback_speed == (src_reg ? o_observer_speed : o_encoder_speed))
      else $error("feedback not from latched source");
   chk_mode_zero_first: assert property (age_reg >= 8'h02
      && (mode_reg == 4'h0 || mode_reg > 4'hA) |-> !o_second_set_active)
      else $error("second set used in fixed first mode");
   chk_mode_nine_keep: assert property (mode_reg == 4'h9 && o_second_set_active |=>
      o_second_set_active) else $error("left second set in fixed second mode");
   chk_speed_tick_hold: assert property ($changed(o_encoder_speed) |=>
      $stable(o_encoder_speed)[*7]) else $error("encoder speed changed between ticks");
   chk_set_tick_hold: assert property (age_reg >= 8'h02
      && $changed(o_second_set_active) |=> $stable(o_second_set_active)[*7])
      else $error("set changed between ticks");
   chk_pin_selects_second: assert property (mode_reg == 4'h1
      && i_switch_cfg.delay_time == 16'h0000
      && $rose(i_gain_select_input) ##1 i_gain_select_input[*8] |-> ##[0:4] o_second_set_active)
      else $error("select pin did not pick second set");
   chk_pin_selects_first: assert property (mode_reg == 4'h1
      && i_switch_cfg.delay_time == 16'h0000
      && $fell(i_gain_select_input) ##1 !i_gain_select_input[*8] |-> ##[0:4] !o_second_set_active)
      else $error("select pin did not return first set");
   cover property (mode_reg == 4'h1 && $rose(o_second_set_active));
   cover property (mode_reg == 4'h8 && $rose(o_second_set_active));
   cover property (src_reg && rst_d_reg && o_observer_speed != 32'h00000000);
endmodule

// ==== verif/sgsfs_far_model.sv ====
// Far side model: an encoder that advances each clock and the gain select pin.
// Assumes the bench gives the speed in counts per clock and the wanted pin level.
`timescale 1ns/1ps
module sgsfs_far_model (
   // Clock
   input  wire logic               i_sys_clk,
   // Requests from the bench
   input  wire logic signed [31:0] i_velocity,
   input  wire logic               i_select_req,
   // Lines into the block
   output logic signed [31:0]      o_position,
   output logic                    o_gain_select
);
   initial o_position = 32'h00000000;
   initial o_gain_select = 1'b0;
   always @(posedge i_sys_clk) o_position <= o_position + i_velocity;
   // The pin moves off the clock edge, as a real switch would, to exercise the sync
   always @(i_select_req) o_gain_select <= #2 i_select_req;
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for sgsfs_top with an encoder and select pin model.
// Assumes an 8 clock control tick; each test restarts the block to latch its mode.
`timescale 1ns/1ps
module tb;
   localparam int TC = 8;
   logic                         sys_clk, rst_b, src, pos_done, sel_req, sel_pin, second;
   logic [3:0]                   mode;
   logic [15:0]                  obs_gain, filt_time;
   logic signed [31:0]           vel, pos, enc_spd, obs_spd, fb_spd;
   sgsfs_pkg::sgsfs_switch_cfg_t cfg;
   sgsfs_pkg::sgsfs_gain_set_t   g1, g2, gains;
   sgsfs_pkg::sgsfs_monitor_t    mon, mon_v;
   int                           failures, n_compared, qt[5], et[5];
   sgsfs_top #(.TICK_CYCLES(TC)) i_sgsfs_top (.i_sys_clk(sys_clk), .i_rst_b(rst_b),
      .i_gain_switch_mode(mode), .i_feedback_speed_source_select(src), .i_observer_gain(obs_gain),
      .i_encoder_speed_filter_time(filt_time), .i_switch_cfg(cfg), .i_gain_first(g1),
      .i_gain_second(g2), .i_encoder_position(pos), .i_monitor(mon),
      .i_positioning_completed(pos_done), .i_gain_select_input(sel_pin),
      .o_encoder_speed(enc_spd), .o_observer_speed(obs_spd), .o_feedback_speed(fb_spd),
      .o_second_set_active(second), .o_active_gains(gains));
   sgsfs_far_model i_sgsfs_far_model (.i_sys_clk(sys_clk), .i_velocity(vel),
      .i_select_req(sel_req), .o_position(pos), .o_gain_select(sel_pin));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      #1;
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n * TC) @(posedge sys_clk);
   endtask
   task automatic restart(input logic [3:0] m, input logic s);
      @(posedge sys_clk);
      {rst_b, mode, src, sel_req, pos_done, vel, mon} <= {1'b0, m, s, 2'b00, 32'h0, 160'h0};
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      ticks(3);
   endtask
   task automatic complete_run;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {rst_b, mode, src, pos_done, sel_req, vel, mon} = '0;
      {obs_gain, filt_time} = {16'h0400, 16'h0000};
      cfg = {{6{16'h0064}}, 16'h0014, 16'h0000, 16'h0000};
      g1 = {16'h0011, 16'h0022, 16'h0100, 16'h0044};
      g2 = {16'h0055, 16'h0066, 16'h0500, 16'h0088};
      qt = '{112, 136, 88, 64, 136};
      et = '{0, 1, 1, 0, 0};
      restart(4'h0, 1'b0);
      @(posedge sys_clk) {sel_req, pos_done} <= 2'b11;
      ticks(3);
      check(gains, g1);
      restart(4'h9, 1'b0);
      @(posedge sys_clk) mode <= 4'h0;
      ticks(2);
      check(gains, g2);
      for (int k = 0; k < 2; k++) begin
         restart(k ? 4'hA : 4'h1, 1'b0);
         check(gains, g1);
         @(posedge sys_clk) {sel_req, pos_done} <= k ? 2'b01 : 2'b10;
         ticks(3);
         check(gains, g2);
         @(posedge sys_clk) {sel_req, pos_done} <= 2'b00;
         ticks(3);
         check(gains, g1);
      end
      // Band is 80 to 120 around a threshold of 100; mode 8 also needs speed above 100,
      // so its last step keeps the position high but stops the motor
      for (int m = 2; m <= 8; m++) begin
         restart(m[3:0], 1'b0);
         for (int i = 0; i < ((m == 8) ? 5 : 4); i++) begin
            mon_v = '0;
            if (m <= 6) mon_v[(6 - m) * 32 +: 32] = qt[i];
            if (m == 8) mon_v.pos_ref = qt[i];
            @(posedge sys_clk) begin
               mon <= mon_v;
               vel <= (m == 7) ? qt[i] / TC : ((m == 8 && i < 4) ? 17 : 0);
            end
            ticks(5);
            check(second, et[i][0]);
         end
      end
      restart(4'h0, 1'b1);
      @(posedge sys_clk) {vel, obs_gain, src} <= {32'h00000019, 16'h0000, 1'b0};
      ticks(4);
      check(enc_spd, 32'h000000C8);
      check(fb_spd, obs_spd);
      check(obs_spd, 32'h00000000);
      @(posedge sys_clk) obs_gain <= 16'h0400;
      ticks(2);
      check(obs_spd, 32'h000000C8);
      restart(4'h0, 1'b0);
      @(posedge sys_clk) {vel, obs_gain} <= {32'h00000019, 16'h0000};
      ticks(4);
      check(fb_spd, 32'h000000C8);
      // Filter at 1000 gives a shift of 7, so a step is still far from settled
      @(posedge sys_clk) {vel, filt_time} <= {32'h00000032, 16'h03E8};
      ticks(3);
      check(enc_spd > 32'sh000000C8 && enc_spd < 32'sh00000190, 1);
      restart(4'h1, 1'b0);
      @(posedge sys_clk) {sel_req, cfg.delay_time} <= {1'b1, 16'h0003};
      ticks(2);
      check(second, 0);
      ticks(5);
      check(second, 1);
      @(posedge sys_clk) {sel_req, cfg.delay_time, cfg.ramp_time} <= {1'b0, 16'h0000, 16'h0004};
      ticks(8);
      check(gains, g1);
      @(posedge sys_clk) sel_req <= 1'b1;
      ticks(3);
      check(gains.pos_gain > 16'h0100 && gains.pos_gain < 16'h0500, 1);
      ticks(6);
      check(gains, g2);
      complete_run();
   end
   initial begin
      #100000;
      failures++;
      complete_run();
   end
endmodule
bind sgsfs_top sgsfs_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_sgsfs_asserts (
   .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_gain_switch_mode(i_gain_switch_mode),
   .i_feedback_speed_source_select(i_feedback_speed_source_select), .i_switch_cfg(i_switch_cfg),
   .i_gain_first(i_gain_first), .i_gain_second(i_gain_second),
   .i_gain_select_input(i_gain_select_input), .o_encoder_speed(o_encoder_speed),
   .o_observer_speed(o_observer_speed), .o_feedback_speed(o_feedback_speed),
   .o_second_set_active(o_second_set_active), .o_active_gains(o_active_gains));
